/* File: core/low_power_state_controller.v */
// low-power state controller: supply ordering, quiet balancing, periodic checks
// assumes AHB-Lite single slave, 10 MHz hclk, pins synchronised internally
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "lp_state_map.vh"

// Notes on behaviour
// - comm, reference, bootstrap off together
// - main regulator off after delay
// - comm supply starts despite reference failure
// - frames during power-up may be dropped
// - quiet balancing needs bal, select, sleep
// - quiet balancing replaces sleep, balancing runs
// - quiet keeps balance and wake resources
// - valid frame or fault wake returns normal
// - external fault in quiet goes normal
// - target done sets flag, goes sleep
// - cyclic tick in quiet runs check
// - periodic check every coded interval
// - fault in check goes normal
// - link or fault wake leaves check
// - check done returns to prior state
// - on-demand accepted only in normal
// - once checks per visit, others continuous
// - on-demand runs now, resets cyclic counter
// - short detect valid in duty, output
// - wake pin deglitched before wake
// - undervoltage latched after reset delay
// - silence or sleep command leaves normal
module low_power_state_controller #(
	parameter CORE_REG_OFF_CYC = `CORE_REG_OFF_CYC,
	parameter CYCLIC_BASE_CYC = `CYCLIC_BASE_CYC,
	parameter SILENCE_BASE_CYC = `SILENCE_BASE_CYC
) (
	input wire hclk, // block clock, 10 MHz
	input wire hresetn, // async reset, active low
	input wire ce, // clock enable, freezes state when low
	input wire hsel, // slave select
	input wire [31:0] haddr, // byte address
	input wire [1:0] htrans, // transfer type
	input wire hwrite, // write strobe
	input wire [2:0] hsize, // transfer size, word only
	input wire [31:0] hwdata, // write data
	input wire hready, // bus ready
	output wire hreadyout, // slave ready
	output wire hresp, // always OKAY
	output reg [31:0] hrdata, // read data
	input wire link_clk, // serial link clock pin
	input wire link_frame_ok, // pulse: electrically valid frame seen
	input wire fault_line, // fault line pin from upper devices
	input wire wake_pin, // wake pin
	input wire comm_supply_undervolt, // comm supply undervoltage pin
	input wire ref_supply_undervolt, // reference supply undervoltage pin
	input wire ext_fault, // pulse: external fault
	input wire check_fault, // pulse: fault found by periodic check
	input wire checks_done, // pulse: periodic check tasks finished
	input wire bal_target_done, // pulse: balancing target reached
	input wire duty_phase, // general pin in duty phase
	input wire pin_is_output, // general pin configured as output
	input wire short_raw, // raw output short comparator
	output reg comm_supply_en, // comm supply enable
	output reg sensor_ref_en, // sensor reference enable
	output reg bootstrap_en, // bootstrap enable
	output reg main_regulator_en, // main regulator enable
	output reg bal_drv_en, // balance drivers and timer on
	output reg bal_short_cmp_en, // balance short comparators on
	output reg wake_logic_en, // wake logic and sources on
	output reg cont_mon_en, // continuous monitors on
	output reg once_checks_start, // pulse: run once-per-visit checks
	output reg on_demand_run, // pulse: start one on-demand run
	output reg frame_accept, // frames are interpreted
	output reg short_detect // qualified output short
);
	localparam [2:0] SYNC_W = 3'h5;

	wire [4:0] pins_s;
	wire link_clk_s = pins_s[0];
	wire fault_s = pins_s[1];
	wire wake_pin_s = pins_s[2];
	wire comm_uv_s = pins_s[3];
	wire ref_uv_s = pins_s[4];

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg prior_quiet_q;
	reg target_check_q;
	reg [31:0] tmr_q;
	reg [31:0] cyc_q;
	reg [31:0] sil_q;
	reg [10:0] dg_q;
	reg dg_wake_q;
	reg [8:0] uv_cnt_q;
	reg link_clk_prev_q;
	reg fault_prev_q;
	reg [8:0] ctrl_q;
	reg [1:0] sil_sel_q;
	reg bal_done_q;
	reg comm_uv_q;
	reg ref_uv_q;
	reg ap_wr_q;
	reg [7:0] ap_addr_q;
	reg ap_ok_q;

	// pins from outside the clock domain
	pin_sync #(.W(SYNC_W)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.pin_in({ref_supply_undervolt, comm_supply_undervolt, wake_pin, fault_line, link_clk}),
		.pin_out(pins_s)
	);

	// bus answers in zero wait states; frozen clock holds the bus
	assign hreadyout = ce;
	assign hresp = 1'b0;

	wire ap_take = hsel & hready & htrans[1] & ce;
	wire dp_wr = ap_ok_q & ap_wr_q & ce;
	wire wr_ctrl = dp_wr & (ap_addr_q == `OFF_CTRL);
	wire wr_status = dp_wr & (ap_addr_q == `OFF_STATUS);
	wire go_sleep_cmd = wr_ctrl & hwdata[`CTRL_GO_SLEEP];
	wire soft_rst = wr_ctrl & hwdata[`CTRL_SOFT_RST];
	wire bal_on = ctrl_q[`CTRL_BAL_ON];
	wire slp_bal_sel = ctrl_q[`CTRL_SLP_BAL_SEL];
	wire [2:0] ivl_code = ctrl_q[`CTRL_IVL_HI:`CTRL_IVL_LO];
	wire link_act = link_clk_s ^ link_clk_prev_q;
	wire fault_wake = fault_s & ~fault_prev_q;
	// valid frame, fault edge or deglitched pin wake
	wire any_wake = link_frame_ok | fault_wake | dg_wake_q;
	// interval is the base doubled per code step
	wire [31:0] cyc_limit = CYCLIC_BASE_CYC[31:0] << ivl_code;
	wire cyc_tick = (cyc_q >= cyc_limit - 32'h0000_0001);
	reg [31:0] sil_mul;
	wire [31:0] sil_limit = sil_mul * SILENCE_BASE_CYC[31:0];
	wire sil_expired = ~ctrl_q[`CTRL_SIL_DIS] & (sil_q >= sil_limit);
	wire od_req = wr_ctrl & hwdata[`CTRL_ON_DEMAND] & (state_q == `S_NORMAL);
	// quiet entry needs balancing on and select set; a write in the same word counts
	wire want_quiet = soft_rst ? 1'b0 : wr_ctrl ? (hwdata[`CTRL_BAL_ON] & hwdata[`CTRL_SLP_BAL_SEL]) :
		(bal_on & slp_bal_sel);

	// silence timeout multiplier by select
	always @* begin
		case (sil_sel_q)
			2'h0: sil_mul = `SIL_MUL_00;
			2'h1: sil_mul = `SIL_MUL_01;
			2'h2: sil_mul = `SIL_MUL_10;
			default: sil_mul = `SIL_MUL_11;
		endcase
	end

	// bus address phase and read data
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_ok_q <= 1'b0;
			ap_wr_q <= 1'b0;
			ap_addr_q <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else if (ce) begin
			ap_ok_q <= ap_take & (haddr[31:8] == 24'h00_0000);
			ap_wr_q <= hwrite;
			ap_addr_q <= haddr[7:0];
			if (ap_take & ~hwrite) begin
				// unmapped offsets read as zero
				hrdata <= 32'h0000_0000;
				if (haddr[31:8] == 24'h00_0000) begin
					case (haddr[7:0])
						`OFF_CTRL: hrdata <= {23'h00_0000, ctrl_q};
						`OFF_STATUS: hrdata <= {24'h00_0000, (uv_cnt_q == `UV_LATCH_CYC), ref_uv_q,
							comm_uv_q, bal_done_q, 1'b0, state_q};
						`OFF_CYCLIC: hrdata <= cyc_q;
						default: hrdata <= 32'h0000_0000;
					endcase
				end
			end
		end
	end

	// control register and soft reset
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `CTRL_RESET;
			sil_sel_q <= `SIL_RESET;
		end else if (ce) begin
			if (soft_rst) begin
				// timeout select kept across soft reset
				ctrl_q <= `CTRL_RESET;
			end else if (wr_ctrl) begin
				ctrl_q <= hwdata[8:0];
				sil_sel_q <= hwdata[`CTRL_SIL_HI:`CTRL_SIL_LO];
			end
		end
	end

	// done flag, set wins over the clear
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bal_done_q <= 1'b0;
		end else if (ce) begin
			if (bal_target_done & (state_q == `S_QUIET)) begin
				bal_done_q <= 1'b1;
			end else if (wr_status & hwdata[`ST_BAL_DONE]) begin
				bal_done_q <= 1'b0;
			end
		end
	end

	// undervoltage latched only after the post-reset delay
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			uv_cnt_q <= 9'h000;
			comm_uv_q <= 1'b0;
			ref_uv_q <= 1'b0;
		end else if (ce) begin
			if (uv_cnt_q != `UV_LATCH_CYC) begin
				uv_cnt_q <= uv_cnt_q + 9'h001;
			end else begin
				// sticky, write one clears, a new event wins
				comm_uv_q <= comm_uv_s | (comm_uv_q & ~(wr_status & hwdata[`ST_COMM_UV]));
				ref_uv_q <= ref_uv_s | (ref_uv_q & ~(wr_status & hwdata[`ST_REF_UV]));
			end
		end
	end

	// wake pin must stay high through the filter
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dg_q <= 11'h000;
			dg_wake_q <= 1'b0;
		end else if (ce) begin
			dg_wake_q <= 1'b0;
			if (!(wake_pin_s & ctrl_q[`CTRL_WAKE_PIN_EN])) begin
				dg_q <= 11'h000;
			end else if (dg_q == `DEGLITCH_CYC - 1) begin
				dg_wake_q <= 1'b1;
			end else begin
				dg_q <= dg_q + 11'h001;
			end
		end
	end

	// link activity edges, fault edge, silence counter
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link_clk_prev_q <= 1'b0;
			fault_prev_q <= 1'b0;
			sil_q <= 32'h0000_0000;
		end else if (ce) begin
			link_clk_prev_q <= link_clk_s;
			fault_prev_q <= fault_s;
			if (link_act | (state_q != `S_NORMAL)) begin
				sil_q <= 32'h0000_0000;
			end else if (!sil_expired) begin
				sil_q <= sil_q + 32'h0000_0001;
			end
		end
	end

	// cyclic counter; low-power ticks are acted on
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc_q <= 32'h0000_0000;
		end else if (ce) begin
			if (cyc_tick | od_req) begin
				cyc_q <= 32'h0000_0000;
			end else begin
				cyc_q <= cyc_q + 32'h0000_0001;
			end
		end
	end

	// state machine next state
	always @* begin
		state_d = state_q;
		case (state_q)
			`S_SLEEP: begin
				if (any_wake | cyc_tick) begin
					state_d = `S_POWERUP;
				end
			end
			`S_POWERUP: begin
				// done when comm supply is up, reference not awaited
				if (!comm_uv_s) begin
					state_d = target_check_q ? `S_CHECK : `S_NORMAL;
				end
			end
			`S_NORMAL: begin
				// silence or sleep command leaves normal
				if (go_sleep_cmd | sil_expired) begin
					state_d = `S_PWRDN;
				end
			end
			`S_PWRDN: begin
				// main regulator waits for the off delay
				if (tmr_q >= CORE_REG_OFF_CYC - 1) begin
					state_d = target_check_q ? `S_QUIET : `S_SLEEP;
				end
			end
			`S_QUIET: begin
				if (any_wake | ext_fault) begin
					state_d = `S_POWERUP;
				end else if (bal_target_done) begin
					state_d = `S_SLEEP;
				end else if (cyc_tick) begin
					state_d = `S_POWERUP;
				end
			end
			`S_CHECK: begin
				// fault and wake go to normal
				if (check_fault | any_wake) begin
					state_d = `S_NORMAL;
				end else if (checks_done) begin
					state_d = `S_PWRDN;
				end
			end
			default: state_d = `S_SLEEP;
		endcase
	end

	// state, destination flags and the shared timer
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= `S_SLEEP;
			prior_quiet_q <= 1'b0;
			target_check_q <= 1'b0;
			tmr_q <= 32'h0000_0000;
		end else if (ce) begin
			state_q <= state_d;
			tmr_q <= (state_d == state_q) ? tmr_q + 32'h0000_0001 : 32'h0000_0000;
			if ((state_q == `S_SLEEP) | (state_q == `S_QUIET)) begin
				prior_quiet_q <= (state_q == `S_QUIET);
				// periodic checks from sleep or quiet
				target_check_q <= cyc_tick & ~any_wake & ~(state_q == `S_QUIET & (ext_fault | bal_target_done));
			end
			if ((state_q == `S_NORMAL) & (state_d == `S_PWRDN)) begin
				// quiet picked when entry conditions hold
				target_check_q <= want_quiet;
			end
			if ((state_q == `S_CHECK) & (state_d == `S_PWRDN)) begin
				// prior state and select decide the return
				target_check_q <= prior_quiet_q & slp_bal_sel;
			end
		end
	end

	// supplies and resource enables, registered from the next state
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			comm_supply_en <= 1'b0;
			sensor_ref_en <= 1'b0;
			bootstrap_en <= 1'b0;
			main_regulator_en <= 1'b0;
			bal_drv_en <= 1'b0;
			bal_short_cmp_en <= 1'b0;
			wake_logic_en <= 1'b1;
			cont_mon_en <= 1'b0;
			once_checks_start <= 1'b0;
			on_demand_run <= 1'b0;
			frame_accept <= 1'b0;
			short_detect <= 1'b0;
		end else if (ce) begin
			// outer supplies switch off in the same step
			comm_supply_en <= (state_d == `S_POWERUP) | (state_d == `S_NORMAL) | (state_d == `S_CHECK);
			sensor_ref_en <= (state_d == `S_POWERUP) | (state_d == `S_NORMAL) | (state_d == `S_CHECK);
			bootstrap_en <= (state_d == `S_POWERUP) | (state_d == `S_NORMAL) | (state_d == `S_CHECK);
			// main regulator held through power-down delay
			main_regulator_en <= (state_d == `S_POWERUP) | (state_d == `S_NORMAL) | (state_d == `S_CHECK) |
				(state_d == `S_PWRDN);
			// balance resources live in quiet balancing
			bal_drv_en <= (state_d == `S_QUIET);
			bal_short_cmp_en <= (state_d == `S_QUIET);
			wake_logic_en <= (state_d != `S_NORMAL);
			// continuous monitors in normal and check
			cont_mon_en <= (state_d == `S_NORMAL) | (state_d == `S_CHECK);
			once_checks_start <= (state_d == `S_CHECK) & (state_q != `S_CHECK);
			// on-demand starts one run at once
			on_demand_run <= od_req;
			frame_accept <= (state_d == `S_NORMAL);
			// short only in duty phase on an output
			short_detect <= short_raw & duty_phase & pin_is_output & cont_mon_en;
		end
	end
endmodule // low_power_state_controller

/* File: core/lp_state_map.vh */
// constants for the low-power state controller: clock, timing, registers, states
// assumes a single 10 MHz clock drives every counter
`ifndef LP_STATE_MAP_VH
`define LP_STATE_MAP_VH

`define CLK_HZ 10000000
`define CYC_PER_US (`CLK_HZ / 1000000)
`define CYC_PER_MS (`CLK_HZ / 1000)

// times in their own units, cycle counts derived
`define CORE_REG_OFF_US 500
`define CORE_REG_OFF_CYC (`CORE_REG_OFF_US * `CYC_PER_US)
`define DEGLITCH_US 150
`define DEGLITCH_CYC (`DEGLITCH_US * `CYC_PER_US)
`define UV_LATCH_US 40
`define UV_LATCH_CYC (`UV_LATCH_US * `CYC_PER_US)
`define CYCLIC_BASE_MS 100
`define CYCLIC_BASE_CYC (`CYCLIC_BASE_MS * `CYC_PER_MS)
`define SILENCE_BASE_MS 32
`define SILENCE_BASE_CYC (`SILENCE_BASE_MS * `CYC_PER_MS)

// silence timeout multipliers of the base (32, 256, 1024, 2048 ms)
`define SIL_MUL_00 32'h0000_0001
`define SIL_MUL_01 32'h0000_0008
`define SIL_MUL_10 32'h0000_0020
`define SIL_MUL_11 32'h0000_0040

// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_CYCLIC 8'h08

// control register fields
`define CTRL_BAL_ON 0
`define CTRL_SLP_BAL_SEL 1
`define CTRL_SIL_LO 2
`define CTRL_SIL_HI 3
`define CTRL_SIL_DIS 4
`define CTRL_IVL_LO 5
`define CTRL_IVL_HI 7
`define CTRL_WAKE_PIN_EN 8
`define CTRL_GO_SLEEP 16
`define CTRL_SOFT_RST 17
`define CTRL_ON_DEMAND 18

// status register fields
`define ST_STATE_LO 0
`define ST_STATE_HI 2
`define ST_BAL_DONE 4
`define ST_COMM_UV 5
`define ST_REF_UV 6
`define ST_UV_ARMED 7

// reset values
`define CTRL_RESET 9'h000
`define SIL_RESET 2'h0

// controller states
`define S_SLEEP 3'h0
`define S_POWERUP 3'h1
`define S_NORMAL 3'h2
`define S_PWRDN 3'h3
`define S_QUIET 3'h4
`define S_CHECK 3'h5

`endif

/* File: core/pin_sync.v */
// three-stage synchroniser for a group of pins from outside the clock domain
// assumes the clock enable freezes it like the rest of the block
`timescale 1ns/1ps
module pin_sync #(
	parameter W = 1
) (
	input wire hclk, // block clock
	input wire hresetn, // async reset, active low
	input wire ce, // clock enable
	input wire [W-1:0] pin_in, // raw asynchronous pins
	output wire [W-1:0] pin_out // filtered level
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	reg [W-1:0] out_q;
	genvar i;

	// a change is taken only once stages two and three agree
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					s1_q[i] <= 1'b0;
					s2_q[i] <= 1'b0;
					s3_q[i] <= 1'b0;
					out_q[i] <= 1'b0;
				end else if (ce) begin
					s1_q[i] <= pin_in[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					if (s2_q[i] == s3_q[i]) begin
						out_q[i] <= s3_q[i];
					end
				end
			end
		end
	endgenerate

	assign pin_out = out_q;
endmodule // pin_sync

/* File: tb/lp_monitor.sv */
// checker: timing relations at the low-power controller's ports
// assumes a bind into low_power_state_controller, one hclk domain
`timescale 1ns/1ps
module lp_monitor #(
	parameter CORE_REG_OFF_CYC = 20
) (
	input wire hclk, // block clock
	input wire hresetn, // reset, active low
	input wire link_frame_ok, // valid frame pulse
	input wire ext_fault, // external fault pulse
	input wire check_fault, // check fault pulse
	input wire bal_target_done, // target reached pulse
	input wire duty_phase, // duty phase
	input wire pin_is_output, // pin is output
	input wire short_raw, // raw short
	input wire comm_supply_en, // comm supply
	input wire sensor_ref_en, // reference supply
	input wire bootstrap_en, // bootstrap
	input wire main_regulator_en, // main regulator
	input wire bal_drv_en, // balance drivers
	input wire bal_short_cmp_en, // balance comparators
	input wire wake_logic_en, // wake logic
	input wire cont_mon_en, // continuous monitors
	input wire once_checks_start, // once checks pulse
	input wire on_demand_run, // on-demand pulse
	input wire frame_accept, // frames interpreted
	input wire short_detect // qualified short
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// cycles spent with outer supplies off but the main regulator still on
	reg [15:0] off_cnt_q;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			off_cnt_q <= 16'h0000;
		else if (comm_supply_en || !main_regulator_en)
			off_cnt_q <= 16'h0000;
		else
			off_cnt_q <= off_cnt_q + 16'h0001;
	end

	AST_OUTER_OFF: assert property (($fell(comm_supply_en) || $fell(sensor_ref_en) || $fell(bootstrap_en)) |->
		!comm_supply_en && !sensor_ref_en && !bootstrap_en && main_regulator_en)
		else $error("outer supplies not switched off together");
	AST_MAIN_DELAY: assert property ($fell(main_regulator_en) |->
		off_cnt_q >= CORE_REG_OFF_CYC - 2 && off_cnt_q <= CORE_REG_OFF_CYC + 1)
		else $error("main regulator off delay wrong");
	AST_QUIET_KEEP: assert property (bal_drv_en |-> bal_short_cmp_en && wake_logic_en && !frame_accept)
		else $error("quiet balancing resources missing");
	AST_FRAME_LEAVES_QUIET: assert property (bal_drv_en && link_frame_ok |-> ##[1:2] !bal_drv_en)
		else $error("frame did not stop balancing");
	AST_FAULT_LEAVES_QUIET: assert property (bal_drv_en && ext_fault |-> ##[1:2] !bal_drv_en)
		else $error("external fault did not stop balancing");
	AST_DONE_TO_SLEEP: assert property (bal_drv_en && bal_target_done && !ext_fault && !link_frame_ok |->
		##[1:2] (!bal_drv_en && !cont_mon_en && wake_logic_en))
		else $error("target done did not go to sleep");
	AST_CHECK_FAULT: assert property (cont_mon_en && wake_logic_en && check_fault |-> ##[1:3] frame_accept)
		else $error("check fault did not reach normal");
	AST_ONCE_SINGLE: assert property (once_checks_start |=> (!once_checks_start) [*8])
		else $error("once checks started twice");
	AST_ONDEMAND_NORMAL: assert property (on_demand_run |-> $past(frame_accept))
		else $error("on-demand run outside normal");
	AST_SHORT_QUAL: assert property (short_detect |-> $past(duty_phase) && $past(pin_is_output) && $past(short_raw))
		else $error("short flagged without qualification");
endmodule // lp_monitor

bind low_power_state_controller lp_monitor #(.CORE_REG_OFF_CYC(CORE_REG_OFF_CYC)) i_mon (.hclk, .hresetn,
	.link_frame_ok, .ext_fault, .check_fault, .bal_target_done, .duty_phase, .pin_is_output, .short_raw,
	.comm_supply_en, .sensor_ref_en, .bootstrap_en, .main_regulator_en, .bal_drv_en, .bal_short_cmp_en,
	.wake_logic_en, .cont_mon_en, .once_checks_start, .on_demand_run, .frame_accept, .short_detect);

/* File: tb/host_link_model.sv */
// host model: serial link activity and the fault line from upper devices
// assumes the bench calls its tasks just after a rising hclk edge
`timescale 1ns/1ps
module host_link_model #(
	parameter GAP_CYC = 30
) (
	input wire hclk, // block clock
	output reg link_clk, // link clock, still between frames
	output reg link_frame_ok, // valid frame pulse
	output reg fault_line // fault line
);
	// idle levels: link clock parked low, no fault
	initial begin
		link_clk = 1'b0;
		link_frame_ok = 1'b0;
		fault_line = 1'b0;
	end

	// eight link clocks at 800 ns, off the hclk phase, then the valid pulse
	// quiet after frame
	task frame;
		begin
			#37;
			repeat (16) #400 link_clk = ~link_clk;
			@(posedge hclk);
			link_frame_ok <= 1'b1;
			@(posedge hclk);
			link_frame_ok <= 1'b0;
			repeat (GAP_CYC) @(posedge hclk);
		end
	endtask

	// fault line raised long enough to pass the synchroniser
	task fault;
		begin
			fault_line <= 1'b1;
			repeat (20) @(posedge hclk);
			fault_line <= 1'b0;
			repeat (5) @(posedge hclk);
		end
	endtask
endmodule // host_link_model

/* File: tb/tb_top.sv */
// bench for the low-power controller: bus tasks, one task per scenario
// assumes short count parameters; checker bound into the design
`timescale 1ns/1ps
module tb_top;
	localparam OFF = 20;
	localparam CYB = 200;
	localparam SIB = 1000;
	reg hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, wake_pin = 1'b0, auto_done = 1'b1;
	reg [1:0] htrans = 2'h0;
	reg [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rv;
	reg comm_supply_undervolt = 1'b1, ref_supply_undervolt = 1'b1, ext_fault = 1'b0, check_fault = 1'b0;
	reg checks_done = 1'b0, bal_target_done = 1'b0, duty_phase = 1'b0, pin_is_output = 1'b0, short_raw = 1'b0;
	reg [2:0] dl_q = 3'h0;
	wire [31:0] hrdata;
	wire hreadyout, hresp, link_clk, link_frame_ok, fault_line, comm_supply_en, sensor_ref_en, bootstrap_en;
	wire main_regulator_en, bal_drv_en, bal_short_cmp_en, wake_logic_en, cont_mon_en, once_checks_start;
	wire on_demand_run, frame_accept, short_detect;
	integer err_count = 0, tests_run = 0;

	low_power_state_controller #(.CORE_REG_OFF_CYC(OFF), .CYCLIC_BASE_CYC(CYB), .SILENCE_BASE_CYC(SIB)) i_dut (
		.hclk, .hresetn, .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .link_clk, .link_frame_ok, .fault_line, .wake_pin,
		.comm_supply_undervolt, .ref_supply_undervolt, .ext_fault, .check_fault, .checks_done, .bal_target_done,
		.duty_phase, .pin_is_output, .short_raw, .comm_supply_en, .sensor_ref_en, .bootstrap_en,
		.main_regulator_en, .bal_drv_en, .bal_short_cmp_en, .wake_logic_en, .cont_mon_en, .once_checks_start,
		.on_demand_run, .frame_accept, .short_detect);
	host_link_model i_host (.hclk, .link_clk, .link_frame_ok, .fault_line);

	always #50 hclk = ~hclk;

	// check tasks finish a few cycles into each visit, unless held off
	always @(posedge hclk) begin
		dl_q <= once_checks_start ? 3'h4 : (dl_q != 3'h0 ? dl_q - 3'h1 : 3'h0);
		checks_done <= auto_done && dl_q == 3'h1;
	end

	task chk(input c, input integer id);
		begin
			tests_run = tests_run + 1;
			if (c !== 1'b1) begin
				err_count = err_count + 1;
				$display("unexpected at %0t: check %0d failed", $time, id);
			end
		end
	endtask

	// one single transfer; the wait is bounded only by the watchdog
	task bus(input w, input [11:0] a, input [31:0] wd);
		begin
			haddr <= {20'h0_0000, a};
			hwrite <= w;
			htrans <= 2'h2;
			do @(posedge hclk); while (hreadyout !== 1'b1);
			htrans <= 2'h0;
			hwdata <= wd;
			do @(posedge hclk); while (hreadyout !== 1'b1);
			rv = hrdata;
		end
	endtask

	task wr(input [11:0] a, input [31:0] d);
		bus(1'b1, a, d);
	endtask

	task rd(input [11:0] a);
		bus(1'b0, a, 32'h0000_0000);
	endtask

	// poll the state field until it matches or the limit runs out
	task wst(input [2:0] s, input integer lim);
		integer i;
		begin
			i = 0;
			do begin
				rd(12'h004);
				i = i + 1;
			end while (rv[2:0] !== s && i < lim);
			chk(rv[2:0] === s, 100 + s);
		end
	endtask

	task wait_once(output integer n);
		begin
			n = 0;
			do begin
				@(posedge hclk);
				n = n + 1;
			end while (once_checks_start !== 1'b1 && n < 3000);
			chk(once_checks_start === 1'b1, 5);
		end
	endtask

	task pulse_ext;
		begin
			ext_fault <= 1'b1;
			@(posedge hclk);
			ext_fault <= 1'b0;
		end
	endtask

	// reset values and an unmapped access
	task t_reset;
		begin
			wr(12'h100, 32'hFFFF_FFFF);
			rd(12'h100);
			chk(rv === 32'h0000_0000, 1);
			rd(12'h000);
			chk(rv === 32'h0000_0000, 2);
			chk(wake_logic_en === 1'b1 && comm_supply_en === 1'b0 && main_regulator_en === 1'b0 && hresp === 1'b0, 3);
		end
	endtask

	// wake by frame with the reference failing; late latch of undervoltage
	task t_wake;
		begin
			i_host.frame();
			chk(frame_accept === 1'b0 && comm_supply_en === 1'b1, 10);
			comm_supply_undervolt <= 1'b0;
			wst(3'h2, 40);
			repeat (400) @(posedge hclk);
			rd(12'h004);
			chk(rv[7:5] === 3'h6, 11);
		end
	endtask

	// sleep command with balancing on and select set
	task t_quiet;
		begin
			wr(12'h000, 32'h0001_0003);
			repeat (3) @(posedge hclk);
			chk(!sensor_ref_en && !bootstrap_en && !comm_supply_en && main_regulator_en === 1'b1, 20);
			wst(3'h4, 40);
			chk(main_regulator_en === 1'b0 && bal_drv_en === 1'b1 && bal_short_cmp_en === 1'b1, 21);
		end
	endtask

	// periodic visit from quiet: fault exit, then a clean return
	task t_check;
		integer n;
		begin
			auto_done <= 1'b0;
			wait_once(n);
			repeat (2) @(posedge hclk);
			chk(cont_mon_en === 1'b1 && bal_drv_en === 1'b0, 30);
			check_fault <= 1'b1;
			@(posedge hclk);
			check_fault <= 1'b0;
			wst(3'h2, 20);
			auto_done <= 1'b1;
			wr(12'h000, 32'h0001_0003);
			wst(3'h4, 40);
			wait_once(n);
			repeat (40) @(posedge hclk);
			rd(12'h004);
			chk(rv[2:0] === 3'h4 && bal_drv_en === 1'b1, 31);
		end
	endtask

	// target reached: flag set, sleep, flag cleared by writing one
	task t_done;
		begin
			bal_target_done <= 1'b1;
			@(posedge hclk);
			bal_target_done <= 1'b0;
			wst(3'h0, 20);
			chk(rv[4] === 1'b1, 40);
			wr(12'h004, 32'h0000_0010);
			rd(12'h004);
			chk(rv[4] === 1'b0, 41);
		end
	endtask

	// fault line wake, external fault and frame out of quiet, plain sleep
	task t_exits;
		begin
			i_host.fault();
			wst(3'h2, 50);
			wr(12'h000, 32'h0001_0003);
			wst(3'h4, 40);
			pulse_ext();
			wst(3'h2, 20);
			wr(12'h000, 32'h0001_0003);
			wst(3'h4, 40);
			i_host.frame();
			wst(3'h2, 20);
			wr(12'h000, 32'h0001_0001);
			wst(3'h0, 40);
			chk(bal_drv_en === 1'b0, 50);
		end
	endtask

	// interval codes measured between successive visits
	task t_ivl;
		integer c, n;
		begin
			for (c = 0; c < 3; c = c + 1) begin
				wr(12'h000, {24'h00_0000, c[2:0], 5'h00});
				wait_once(n);
				wait_once(n);
				chk(n === (CYB << c), 60);
			end
		end
	endtask

	task count_demand(output integer s);
		integer i;
		begin
			s = 0;
			wr(12'h000, 32'h0004_0000);
			for (i = 0; i < 3; i = i + 1) begin
				@(posedge hclk);
				if (on_demand_run === 1'b1)
					s = s + 1;
			end
		end
	endtask

	// on-demand restarts the cyclic counter, ignored outside normal
	task t_demand;
		integer s;
		begin
			i_host.fault();
			wst(3'h2, 60);
			count_demand(s);
			chk(s === 1, 70);
			rd(12'h008);
			chk(rv < 32'h0000_0010, 71);
			wr(12'h000, 32'h0001_0000);
			wst(3'h0, 40);
			count_demand(s);
			chk(s === 0, 72);
		end
	endtask

	// short flagged only for a driven output in its duty phase
	task t_short;
		integer k;
		begin
			i_host.fault();
			wst(3'h2, 60);
			for (k = 0; k < 8; k = k + 1) begin
				{duty_phase, pin_is_output, short_raw} <= k[2:0];
				repeat (3) @(posedge hclk);
				chk(short_detect === (k == 7), 80);
			end
			{duty_phase, pin_is_output, short_raw} <= 3'h0;
		end
	endtask

	// wake pin must stay high through the deglitch time
	task t_wakepin;
		begin
			wr(12'h000, 32'h0001_01E0);
			wst(3'h0, 40);
			wake_pin <= 1'b1;
			repeat (1200) @(posedge hclk);
			chk(comm_supply_en === 1'b0 && wake_logic_en === 1'b1, 90);
			repeat (400) @(posedge hclk);
			wst(3'h2, 40);
			wake_pin <= 1'b0;
		end
	endtask

	// longer silence select kept through a soft reset, then timeout
	task t_silence;
		begin
			i_host.frame();
			wr(12'h000, 32'h0000_0010);
			repeat (1500) @(posedge hclk);
			chk(frame_accept === 1'b1, 94);
			wr(12'h000, 32'h0000_0004);
			wr(12'h000, 32'h0002_0000);
			repeat (1500) @(posedge hclk);
			chk(frame_accept === 1'b1, 95);
			wst(3'h0, 5000);
		end
	endtask

	task report_and_stop;
		begin
			$display("mismatches %0d, checks %0d", err_count, tests_run);
			if (err_count == 0 && tests_run > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask

	// main sequence
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset;
		t_wake;
		t_quiet;
		t_check;
		t_done;
		t_exits;
		t_ivl;
		t_demand;
		t_short;
		t_wakepin;
		t_silence;
		report_and_stop;
	end

	// run is near 1.4 ms; a hang is cut well past that
	initial begin
		#5000000;
		err_count = err_count + 1;
		report_and_stop;
	end
endmodule // tb_top
